//--- nonvolatile_write_erase_ctrl.v
// Self-programming controller for program flash rows and the mapped data EEPROM
//
// Functional notes
// - Erase or program needs 0x55 then 0xAA key
// - EEPROM mapped at 0x7FF000 to 0x7FFFFE, 2K words
// - EEPROM single word and 16-word block operations
// - EEPROM target from low plus upper address
// - EEPROM write lasts about 2 ms
// - EEPROM operations never stall the core
// - Reads during operation may return undefined data
// - Start bit set-only; hardware clears at completion
// - Write permit gates writes, clear at power-up
// - Interrupting reset sets error, keeps address
// - Completion sets done flag; software clears it
// - Table read returns word at program address
// - Block erase from address registers and start
// - Start needs permit already set, not same write
// - Flash operation stalls core, about 2 ms
// - Control 0x4041 selects flash row erase
`default_nettype none
`include "nvm_ctrl_map.vh"

module nonvolatile_write_erase_ctrl #(
  parameter OP_CYCLES = `NVM_OP_CYCLES,
  parameter TIMER_WIDTH = 18,
  parameter EE_WORDS = 4096,
  parameter BLOCK_WORDS = 16
) (
  input wire clk,
  input wire resetn,
  input wire master_clear_reset,
  input wire watchdog_timer_reset,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [15:0] sfr_addr,
  input wire [15:0] sfr_wdata,
  output reg [15:0] sfr_rdata,
  input wire tbl_rd,
  input wire tbl_wr,
  input wire [23:0] tbl_addr,
  input wire [15:0] tbl_wdata,
  output reg [15:0] tbl_rdata,
  input wire [15:0] flash_rdata,
  output reg flash_op_start,
  output reg flash_op_erase,
  output reg [23:0] flash_op_addr,
  output wire core_stall,
  input wire done_flag_clear,
  output reg write_done_interrupt_flag
);

  // ******************************************************
  // Reset release
  // ******************************************************
  localparam ST_IDLE = 3'b001;
  localparam ST_EE = 3'b010;
  localparam ST_FLASH = 3'b100;
  localparam KEY_NONE = 3'b001;
  localparam KEY_FIRST = 3'b010;
  localparam KEY_ARMED = 3'b100;

  reg rst_meta;
  reg rst_n;

  // Two-stage release of the power-on reset
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ******************************************************
  // Register state
  // ******************************************************
  reg [2:0] state;
  reg [2:0] key_state;
  reg start_bit;
  reg permit_bit;
  reg error_bit;
  reg bit_eight;
  reg [6:0] op_select;
  reg [15:0] address_low;
  reg [7:0] address_upper;
  reg [6:0] run_op;
  reg [23:0] run_addr;
  reg [15:0] ee_mem [0:EE_WORDS-1];
  reg [15:0] latch [0:BLOCK_WORDS-1];
  wire timer_done;
  wire timer_running;
  reg op_go;
  reg soft_reset;
  integer i;

  wire sel_control = (sfr_addr == `NVM_OFS_CONTROL);
  wire sel_low = (sfr_addr == `NVM_OFS_ADDR_LOW);
  wire sel_upper = (sfr_addr == `NVM_OFS_ADDR_UPPER);
  wire sel_key = (sfr_addr == `NVM_OFS_UNLOCK_KEY);
  wire [23:0] target = {address_upper, address_low};
  wire tbl_in_ee = (tbl_addr >= `NVM_EE_FIRST) && (tbl_addr <= `NVM_EE_LAST);
  wire [11:0] tbl_index = tbl_addr[12:1];
  wire [3:0] tbl_slot = tbl_addr[4:1];
  wire [11:0] run_index = run_addr[12:1];
  wire [7:0] run_block = run_addr[12:5];
  wire target_in_ee = (target >= `NVM_EE_FIRST) && (target <= `NVM_EE_LAST);
  wire [3:0] op_kind = op_select[3:0];
  wire op_known = (op_kind == `NVM_OP_FLASH_ROW) || (op_kind == `NVM_OP_EE_WORD) ||
                  (op_kind == `NVM_OP_EE_BLOCK);
  wire op_is_flash = (op_kind == `NVM_OP_FLASH_ROW);

  // A start request: armed key, permit already set, start bit written high
  wire start_req = sfr_wr && sel_control && sfr_wdata[`NVM_BIT_START] &&
                   (key_state == KEY_ARMED) && permit_bit && !start_bit &&
                   op_known && (op_is_flash || target_in_ee);

  // Interrupting resets arrive from the reset controller on this clock
  always @* begin
    soft_reset = master_clear_reset || watchdog_timer_reset;
    op_go = start_req && !soft_reset;
  end

  // ******************************************************
  // Operation timer
  // ******************************************************
  nvm_op_timer #(
    .CYCLES(OP_CYCLES),
    .WIDTH(TIMER_WIDTH)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(op_go),
    .abort(soft_reset),
    .running(timer_running),
    .done(timer_done)
  );

  // Core waits only while a flash operation runs
  assign core_stall = (state == ST_FLASH);

  // ******************************************************
  // Unlock sequence
  // ******************************************************
  // Key steps advance only on key writes with no other bus access between them
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_state <= KEY_NONE;
    end else if (soft_reset) begin
      key_state <= KEY_NONE;
    end else if (sfr_wr && sel_key && sfr_wdata == `NVM_KEY_FIRST) begin
      key_state <= KEY_FIRST;
    end else if (sfr_wr && sel_key && sfr_wdata == `NVM_KEY_SECOND &&
                 key_state == KEY_FIRST) begin
      key_state <= KEY_ARMED;
    end else if (sfr_wr || sfr_rd || tbl_rd || tbl_wr) begin
      key_state <= KEY_NONE;
    end
  end

  // ******************************************************
  // Control register and sequencer
  // ******************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      start_bit <= 1'b0;
      permit_bit <= 1'b0;
      error_bit <= 1'b0;
      bit_eight <= 1'b0;
      op_select <= 7'h00;
      run_op <= 7'h00;
      run_addr <= 24'h000000;
    end else if (soft_reset) begin
      // Control clears, error records an interrupted operation
      state <= ST_IDLE;
      start_bit <= 1'b0;
      permit_bit <= 1'b0;
      bit_eight <= 1'b0;
      op_select <= 7'h00;
      error_bit <= start_bit;
    end else begin
      if (sfr_wr && sel_control) begin
        permit_bit <= sfr_wdata[`NVM_BIT_WRITE_PERMIT];
        error_bit <= sfr_wdata[`NVM_BIT_INTERRUPTED];
        if (!start_bit) begin
          bit_eight <= sfr_wdata[`NVM_BIT_EIGHT];
          op_select <= sfr_wdata[`NVM_OPSEL_MSB:`NVM_OPSEL_LSB];
        end
      end
      case (state)
        ST_IDLE: begin
          if (op_go) begin
            start_bit <= 1'b1;
            run_op <= op_select;
            run_addr <= target;
            state <= op_is_flash ? ST_FLASH : ST_EE;
          end
        end
        ST_EE, ST_FLASH: begin
          if (timer_done) begin
            start_bit <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Pulse toward the flash array at the start of a flash operation
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_op_start <= 1'b0;
      flash_op_erase <= 1'b0;
      flash_op_addr <= 24'h000000;
    end else begin
      flash_op_start <= op_go && op_is_flash;
      if (op_go && op_is_flash) begin
        flash_op_erase <= op_select[`NVM_OPSEL_ERASE_BIT];
        flash_op_addr <= target;
      end
    end
  end

  // ******************************************************
  // Address registers
  // ******************************************************
  // Table accesses capture their address; no reset but power-up touches them
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      address_low <= `NVM_ADDR_RESET;
      address_upper <= 8'h00;
    end else if (sfr_wr && sel_low) begin
      address_low <= sfr_wdata;
    end else if (sfr_wr && sel_upper) begin
      address_upper <= sfr_wdata[7:0];
    end else if (tbl_rd || tbl_wr) begin
      address_low <= tbl_addr[15:0];
      address_upper <= tbl_addr[23:16];
    end
  end

  // ******************************************************
  // Done flag
  // ******************************************************
  // Completion wins over a clear in the same cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_done_interrupt_flag <= 1'b0;
    end else if (timer_done) begin
      write_done_interrupt_flag <= 1'b1;
    end else if (done_flag_clear) begin
      write_done_interrupt_flag <= 1'b0;
    end
  end

  // ******************************************************
  // EEPROM array and write latches
  // ******************************************************
  // Table writes fill latches; completion commits erase or program
  always @(posedge clk) begin
    if (tbl_wr && tbl_in_ee) begin
      latch[tbl_slot] <= tbl_wdata;
    end
    if (timer_done && state == ST_EE) begin
      if (run_op[3:0] == `NVM_OP_EE_BLOCK) begin
        for (i = 0; i < BLOCK_WORDS; i = i + 1) begin
          ee_mem[{run_block, i[3:0]}] <= run_op[`NVM_OPSEL_ERASE_BIT] ?
                                         `NVM_EE_ERASED : latch[i];
        end
      end else begin
        ee_mem[run_index] <= run_op[`NVM_OPSEL_ERASE_BIT] ?
                             `NVM_EE_ERASED : latch[run_index[3:0]];
      end
    end
  end

  // ******************************************************
  // Read data
  // ******************************************************
  // Table read answers one cycle later; EEPROM data during an operation is old
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tbl_rdata <= 16'h0000;
    end else if (tbl_rd) begin
      tbl_rdata <= tbl_in_ee ? ee_mem[tbl_index] : flash_rdata;
    end
  end

  // Register reads; key reads as zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 16'h0000;
    end else if (sfr_rd) begin
      if (sel_control) begin
        sfr_rdata <= {start_bit, permit_bit, error_bit, 4'h0, bit_eight, 1'b0, op_select};
      end else if (sel_low) begin
        sfr_rdata <= address_low;
      end else if (sel_upper) begin
        sfr_rdata <= {8'h00, address_upper} & `NVM_UPPER_MASK;
      end else begin
        sfr_rdata <= 16'h0000;
      end
    end
  end

endmodule // nonvolatile_write_erase_ctrl

`default_nettype wire

//--- nvm_ctrl_map.vh
// Register offsets, field positions, reset values and timing counts of the nonvolatile controller
`ifndef NVM_CTRL_MAP_VH
`define NVM_CTRL_MAP_VH

// ******************************************************
// Register offsets (byte addresses in the special register space)
// ******************************************************
`define NVM_OFS_CONTROL 16'h0760
`define NVM_OFS_ADDR_LOW 16'h0762
`define NVM_OFS_ADDR_UPPER 16'h0764
`define NVM_OFS_UNLOCK_KEY 16'h0766

// ******************************************************
// Control register fields
// ******************************************************
`define NVM_BIT_START 15
`define NVM_BIT_WRITE_PERMIT 14
`define NVM_BIT_INTERRUPTED 13
`define NVM_BIT_EIGHT 8
`define NVM_OPSEL_MSB 6
`define NVM_OPSEL_LSB 0
`define NVM_OPSEL_ERASE_BIT 6
`define NVM_CONTROL_RESET 16'h0000
`define NVM_ADDR_RESET 16'h0000
`define NVM_UPPER_MASK 16'h00FF

// ******************************************************
// Operation select codes (low four bits of the field)
// ******************************************************
`define NVM_OP_FLASH_ROW 4'h1
`define NVM_OP_EE_WORD 4'h4
`define NVM_OP_EE_BLOCK 4'h5

// ******************************************************
// Unlock key values
// ******************************************************
`define NVM_KEY_FIRST 16'h0055
`define NVM_KEY_SECOND 16'h00AA

// ******************************************************
// Data EEPROM window in program space
// ******************************************************
`define NVM_EE_FIRST 24'h7FF000
`define NVM_EE_LAST 24'h7FFFFE
`define NVM_EE_ERASED 16'hFFFF

// ******************************************************
// Timing
// ******************************************************
`define NVM_OP_TIME_US 2000
`define NVM_CLK_MHZ 100
`define NVM_OP_CYCLES (`NVM_OP_TIME_US * `NVM_CLK_MHZ)

`endif

//--- nvm_op_timer.v
// Down counter that times one erase or program operation
`default_nettype none
`include "nvm_ctrl_map.vh"

module nvm_op_timer #(
  parameter CYCLES = `NVM_OP_CYCLES,
  parameter WIDTH = 18
) (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire abort,
  output reg running,
  output reg done
);

  reg [WIDTH-1:0] count;

  // Load on start, count down, pulse done on the last cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {WIDTH{1'b0}};
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        running <= 1'b0;
        count <= {WIDTH{1'b0}};
      end else if (start) begin
        running <= 1'b1;
        count <= CYCLES[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};
      end else if (running) begin
        if (count == {WIDTH{1'b0}}) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // nvm_op_timer

`default_nettype wire

//--- nvm_ctrl_chk.sv
// Concurrent checks on the ports of the nonvolatile write and erase controller
`default_nettype none
module nvm_ctrl_chk #(
  parameter int OP_CYCLES = 20
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic master_clear_reset,
  input wire logic watchdog_timer_reset,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [15:0] sfr_addr,
  input wire logic [15:0] sfr_wdata,
  input wire logic [15:0] sfr_rdata,
  input wire logic flash_op_start,
  input wire logic core_stall,
  input wire logic done_flag_clear,
  input wire logic write_done_interrupt_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STALL_MIN = OP_CYCLES - 1;
  localparam int STALL_MAX = OP_CYCLES + 2;
  // ****************
  // Helper decode
  // ****************
  // Unlock steps and interrupting resets as seen on the register bus
  wire logic key_one = sfr_wr && sfr_addr == 16'h0766 && sfr_wdata == 16'h0055;
  wire logic key_two = sfr_wr && sfr_addr == 16'h0766 && sfr_wdata == 16'h00AA;
  wire logic go = sfr_wr && sfr_addr == 16'h0760 && sfr_wdata[15];
  wire logic irq_rst = master_clear_reset || watchdog_timer_reset;
  logic [31:0] stall_cnt;
  // Counts the cycles the core has been held so far
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stall_cnt <= 32'h0;
    end else begin
      stall_cnt <= core_stall ? stall_cnt + 32'h1 : 32'h0;
    end
  end
  // ****************
  // Properties
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_op_end;
    core_stall && !irq_rst ##1 !core_stall;
  endsequence
  sequence s_start_burst;
    core_stall ##1 !flash_op_start && core_stall;
  endsequence
  AST_START_AFTER_KEYS: assert property (flash_op_start |->
    ($past(go, 1) && $past(key_two, 2) && $past(key_one, 3)) ||
    ($past(go, 2) && $past(key_two, 3) && $past(key_one, 4)))
    else $error("flash start without unlock");
  AST_STALL_WITH_START: assert property (flash_op_start |-> s_start_burst)
    else $error("flash start without stall");
  AST_STALL_CAUSE: assert property ($rose(core_stall) |-> flash_op_start)
    else $error("stall without flash start");
  AST_STALL_MAX: assert property (stall_cnt <= STALL_MAX)
    else $error("stall too long");
  AST_STALL_MIN: assert property ($fell(core_stall) && !$past(irq_rst) |->
    stall_cnt >= STALL_MIN) else $error("stall too short");
  AST_DONE_AT_END: assert property (s_op_end |-> write_done_interrupt_flag)
    else $error("done flag not set at end");
  AST_FLAG_STICKY: assert property (write_done_interrupt_flag && !done_flag_clear |=>
    write_done_interrupt_flag) else $error("done flag dropped");
  AST_KEY_READ_ZERO: assert property (sfr_rd && sfr_addr == 16'h0766 |=>
    sfr_rdata == 16'h0000) else $error("key reads nonzero");
  AST_UPPER_READ: assert property (sfr_rd && sfr_addr == 16'h0764 |=>
    sfr_rdata[15:8] == 8'h00) else $error("upper address high byte nonzero");
endmodule // nvm_ctrl_chk

bind nonvolatile_write_erase_ctrl nvm_ctrl_chk #(.OP_CYCLES(OP_CYCLES)) chk_u (
  .clk(clk), .resetn(resetn), .master_clear_reset(master_clear_reset),
  .watchdog_timer_reset(watchdog_timer_reset), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .flash_op_start(flash_op_start), .core_stall(core_stall),
  .done_flag_clear(done_flag_clear), .write_done_interrupt_flag(write_done_interrupt_flag));
`default_nettype wire

//--- flash_array_model.sv
// Behavioural program flash array that answers reads and records operations
`default_nettype none
module flash_array_model (
  input wire logic clk,
  input wire logic [23:0] tbl_addr,
  input wire logic flash_op_start,
  input wire logic flash_op_erase,
  input wire logic [23:0] flash_op_addr,
  output logic [15:0] flash_rdata,
  output logic [7:0] starts,
  output logic [23:0] last_addr,
  output logic last_erase
);
  timeunit 1ns;
  timeprecision 1ps;
  // Stored word is a fixed pattern of its address
  assign flash_rdata = tbl_addr[15:0] ^ 16'h5A3C;
  initial starts = 8'h00;
  // Records each flash operation the controller launches
  always @(posedge clk) begin
    if (flash_op_start) begin
      starts <= starts + 8'h01;
      last_addr <= flash_op_addr;
      last_erase <= flash_op_erase;
    end
  end
endmodule // flash_array_model
`default_nettype wire

//--- nonvolatile_write_erase_ctrl_bench.sv
// Self-checking bench for the nonvolatile write and erase controller
`default_nettype none
module nonvolatile_write_erase_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OPC = 20;
  localparam logic [23:0] CTL = 24'h0760, ALO = 24'h0762, AUP = 24'h0764, KEY = 24'h0766;
  logic clk, resetn, master_clear_reset, watchdog_timer_reset, sfr_wr, sfr_rd, tbl_rd, tbl_wr;
  logic done_flag_clear;
  logic [15:0] sfr_addr, sfr_wdata, tbl_wdata, rv;
  logic [23:0] tbl_addr, a, base;
  logic [15:0] d [16];
  wire logic [15:0] sfr_rdata, tbl_rdata, flash_rdata;
  wire logic flash_op_start, flash_op_erase, core_stall, write_done_interrupt_flag, last_erase;
  wire logic [23:0] flash_op_addr, last_addr;
  wire logic [7:0] starts;
  int fails = 0, n_compared = 0, cycles = 0, seed = 40, i;

  nonvolatile_write_erase_ctrl #(.OP_CYCLES(OPC)) dut_u (.clk(clk), .resetn(resetn),
    .master_clear_reset(master_clear_reset), .watchdog_timer_reset(watchdog_timer_reset),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .tbl_rd(tbl_rd), .tbl_wr(tbl_wr), .tbl_addr(tbl_addr),
    .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata), .flash_rdata(flash_rdata),
    .flash_op_start(flash_op_start), .flash_op_erase(flash_op_erase),
    .flash_op_addr(flash_op_addr), .core_stall(core_stall), .done_flag_clear(done_flag_clear),
    .write_done_interrupt_flag(write_done_interrupt_flag));
  flash_array_model partner_u (.clk(clk), .tbl_addr(tbl_addr), .flash_op_start(flash_op_start),
    .flash_op_erase(flash_op_erase), .flash_op_addr(flash_op_addr), .flash_rdata(flash_rdata),
    .starts(starts), .last_addr(last_addr), .last_erase(last_erase));

  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  // ****************
  // Bus tasks and comparison
  // ****************
  task final_report;
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Strobes are {sfr_wr, sfr_rd, tbl_wr, tbl_rd}, held for one edge
  task cyc(input logic [3:0] s, input logic [23:0] ad, input logic [15:0] wd);
    {sfr_wr, sfr_rd, tbl_wr, tbl_rd} <= s;
    sfr_addr <= ad[15:0];
    tbl_addr <= ad;
    sfr_wdata <= wd;
    tbl_wdata <= wd;
    @(posedge clk);
  endtask
  task idle(input int n);
    repeat (n) cyc(4'h0, tbl_addr, 16'h0000);
  endtask
  task rd(input logic [3:0] s, input logic [23:0] ad);
    cyc(s, ad, 16'h0000);
    idle(1);
    rv = s[0] ? tbl_rdata : sfr_rdata;
  endtask
  // Sets the operation with permit, then unlocks and starts it back to back
  task launch(input logic [15:0] op);
    cyc(4'h8, CTL, 16'h4000 | op);
    cyc(4'h8, KEY, 16'h0055);
    cyc(4'h8, KEY, 16'h00AA);
    cyc(4'h8, CTL, 16'hC000 | op);
    idle(2);
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    {clk, resetn, master_clear_reset, watchdog_timer_reset, sfr_wr, sfr_rd} = 6'h00;
    {tbl_rd, tbl_wr, done_flag_clear, sfr_addr, sfr_wdata, tbl_wdata, tbl_addr} = '0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(4'h4, CTL); chk("control reset", 16'h0000, rv);
    rd(4'h4, KEY); chk("key read", 16'h0000, rv);
    // Target inside the window and permit already set, so only the key can refuse the first two starts
    cyc(4'h8, AUP, 16'h007F); cyc(4'h8, ALO, 16'hF000); cyc(4'h8, CTL, 16'h4004);
    cyc(4'h8, CTL, 16'hC004); idle(1); rd(4'h4, CTL); chk("no key start", 16'h4004, rv);
    cyc(4'h8, KEY, 16'h0055); cyc(4'h4, 24'h0768, 16'h0); cyc(4'h8, KEY, 16'h00AA);
    cyc(4'h8, CTL, 16'hC004); idle(1); rd(4'h4, CTL); chk("broken key", 16'h4004, rv);
    cyc(4'h8, CTL, 16'h0004); cyc(4'h8, KEY, 16'h0055); cyc(4'h8, KEY, 16'h00AA);
    cyc(4'h8, CTL, 16'hC004); idle(1); rd(4'h4, CTL); chk("one write", 16'h4004, rv);
    cyc(4'h8, AUP, 16'h0); cyc(4'h8, ALO, 16'h1000); launch(16'h0004);
    rd(4'h4, CTL); chk("outside window", 16'h4004, rv);
    for (i = 0; i < 3; i++) begin
      a = (i == 0) ? 24'h7FF000 : (i == 1) ? 24'h7FFFFE :
          24'h7FF000 | (24'($random(seed)) & 24'hFFE);
      d[0] = 16'($random(seed));
      cyc(4'h2, a, d[0]); idle(1);
      rd(4'h4, ALO); chk("addr low", a[15:0], rv);
      rd(4'h4, AUP); chk("addr upper", {8'h00, a[23:16]}, rv);
      launch(16'h0044);
      chk("ee stall", 1'b0, core_stall);
      cyc(4'h8, CTL, 16'h4044); rd(4'h4, CTL); chk("start held", 16'hC044, rv);
      idle(OPC + 2);
      rd(4'h4, CTL); chk("after erase", 16'h4044, rv);
      chk("done flag", 1'b1, write_done_interrupt_flag);
      rd(4'h1, a); chk("erased word", 16'hFFFF, rv);
      done_flag_clear <= 1'b1; idle(1); done_flag_clear <= 1'b0; idle(1);
      chk("flag cleared", 1'b0, write_done_interrupt_flag);
      launch(16'h0004); idle(OPC + 2); rd(4'h1, a); chk("word program", d[0], rv);
    end
    base = 24'h7FF000 | (24'($random(seed)) & 24'hFE0);
    for (i = 0; i < 16; i++) begin
      d[i] = 16'($random(seed));
      cyc(4'h2, base + 24'(2 * i), d[i]);
    end
    launch(16'h0005); idle(OPC + 2);
    for (i = 0; i < 16; i++) begin
      rd(4'h1, base + 24'(2 * i)); chk("block word", d[i], rv);
    end
    launch(16'h0045); idle(OPC + 2); rd(4'h1, base + 24'hA); chk("block erase", 16'hFFFF, rv);
    cyc(4'h8, AUP, 16'h0000); cyc(4'h8, ALO, 16'h6000); launch(16'h0041);
    chk("flash stall", 1'b1, core_stall);
    idle(OPC + 2);
    chk("flash starts", 8'h01, starts);
    chk("flash erase", 1'b1, last_erase);
    chk("flash target", 24'h006000, last_addr);
    rd(4'h4, CTL); chk("flash done", 16'h4041, rv);
    rd(4'h1, 24'h001234); chk("flash read", 16'h1234 ^ 16'h5A3C, rv);
    // Flash row program with bit eight set; the field must survive the run
    launch(16'h0101); idle(OPC + 2); chk("flash program", 1'b0, last_erase);
    chk("flash count", 8'h02, starts);
    rd(4'h4, CTL); chk("bit eight kept", 16'h4101, rv);
    for (i = 0; i < 2; i++) begin
      rd(4'h1, base); launch(16'h0044);
      {master_clear_reset, watchdog_timer_reset} <= (i == 0) ? 2'b10 : 2'b01;
      idle(1);
      {master_clear_reset, watchdog_timer_reset} <= 2'b00;
      idle(1);
      rd(4'h4, CTL); chk("interrupted", 16'h2000, rv);
      rd(4'h4, ALO); chk("kept addr", base[15:0], rv);
    end
    // Power-on reset while idle clears a permit bit that was set
    cyc(4'h8, CTL, 16'h4000); resetn <= 1'b0; idle(2); resetn <= 1'b1; idle(3);
    rd(4'h4, CTL); chk("power-up control", 16'h0000, rv);
    final_report();
  end
endmodule // nonvolatile_write_erase_ctrl_bench
`default_nettype wire
